// >>> common/dio_pkg.sv
package dio_pkg;
   // ==========================================================
   // Geometry
   localparam int LINES      = 20;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int DEB_W      = 16;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_DRIVE_ENABLE = 8'h00;
   localparam logic [7:0] OFS_DRIVE_VALUE  = 8'h04;
   localparam logic [7:0] OFS_PIN_LEVEL    = 8'h08;
   localparam logic [7:0] OFS_PULL_SELECT  = 8'h0C;
   localparam logic [7:0] OFS_DEBOUNCE     = 8'h10;
   localparam logic [7:0] OFS_EDGE_ENABLE  = 8'h14;
   localparam logic [7:0] OFS_EDGE_RISING  = 8'h18;
   localparam logic [7:0] OFS_IRQ_STATUS   = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'h20;
   // ==========================================================
   // Pull reference selector
   typedef enum logic [1:0] {
      PULL_OPEN   = 2'b00,
      PULL_UP_3V3 = 2'b01,
      PULL_UP_5V  = 2'b10,
      PULL_DOWN   = 2'b11
   } pull_sel_t;
   // ==========================================================
   // Reset values
   localparam logic [19:0]      RST_LINES    = 20'h0_0000;
   localparam logic [DEB_W-1:0] RST_DEBOUNCE = 16'h0000;
   localparam pull_sel_t        RST_PULL     = PULL_OPEN;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int RD_LATENCY    = 1;
endpackage

// >>> common/level_if.sv
interface level_if #(parameter int W = 20) ();
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   logic [15:0]  limit;
   modport src (output raw, output limit, input clean);
   modport filt (input raw, input limit, output clean);
endinterface

// >>> hw/line_debouncer.sv
module line_debouncer #(
   parameter int W  = 20,
   parameter int CW = 16
) (
   input  wire logic mclk_in,
   input  wire logic reset_in,
   level_if.filt     lv
);
   import dio_pkg::*;
   logic [W-1:0] stable;
   logic [W-1:0] clean;
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_line
         logic [CW-1:0] cnt;
         // A new level must hold limit cycles before it is taken
         always_ff @(posedge mclk_in) begin
            if (reset_in) begin
               cnt       <= '0;
               stable[g] <= 1'b0;
            end else if (lv.raw[g] == stable[g]) begin
               cnt <= '0;
            end else if (cnt + 1'b1 >= lv.limit) begin
               cnt       <= '0;
               stable[g] <= lv.raw[g];
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
         // Zero limit bypasses the filter entirely
         always_comb clean[g] = (lv.limit == '0) ? lv.raw[g] : stable[g];
      end
   endgenerate
   assign lv.clean = clean;
endmodule // line_debouncer

// >>> hw/edge_events.sv
module edge_events #(
   parameter int W = 20
) (
   input  wire logic         mclk_in,
   input  wire logic         reset_in,
   input  wire logic [W-1:0] level_in,
   input  wire logic [W-1:0] enable_in,
   input  wire logic [W-1:0] rising_in,
   output logic      [W-1:0] event_out
);
   logic [W-1:0] prev;
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         prev      <= '0;
         event_out <= '0;
      end else begin
         prev      <= level_in;
         // Rising selected when bit set, falling otherwise
         event_out <= enable_in & ((rising_in & level_in & ~prev) | (~rising_in & ~level_in & prev));
      end
   end
endmodule // edge_events

// >>> hw/digital_io_port.sv
// Function
// - Twenty lines each have their own drive enable and drive value bits.
// - Reset clears every drive enable so all lines start as inputs.
// - One pull reference selector shared by all lines offers open, 3.3V up, 5V up and ground down.
// - The pull selector resets to open and holds it until software changes it.
// - Enable 0 leaves the driver off; enable 1 drives the value bit onto the line.
// - The receiver is always on so the pin level is readable even while driving.
// - Each line can interrupt on a rising or a falling edge.
// - One shared debounce setting applies to all inputs.
//
// Local design decisions: the register offsets and strobed register access.
module digital_io_port #(
   parameter int LINES_P = dio_pkg::LINES
) (
   input  wire logic                      mclk_in,
   input  wire logic                      reset_in,
   input  wire logic [dio_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [dio_pkg::DATA_W-1:0] wdata_in,
   input  wire logic                      wr_in,
   input  wire logic                      rd_in,
   output logic      [dio_pkg::DATA_W-1:0] rdata_out,
   input  wire logic [LINES_P-1:0]        pin_in,
   output logic      [LINES_P-1:0]        pin_out,
   output logic      [LINES_P-1:0]        pin_oe_n_out,
   output logic      [1:0]                pull_sel_out,
   output logic                           irq_out
);
   import dio_pkg::*;

   // ==========================================================
   // Registers
   logic [LINES_P-1:0] line_drive_enable_bit;
   logic [LINES_P-1:0] line_drive_value_bit;
   logic [LINES_P-1:0] edge_enable;
   logic [LINES_P-1:0] edge_rising;
   logic [LINES_P-1:0] irq_status;
   logic [LINES_P-1:0] irq_mask;
   logic [DEB_W-1:0]   debounce;
   pull_sel_t          pull_sel;
   logic [LINES_P-1:0] events;
   logic [LINES_P-1:0] clean_level;
   logic [DATA_W-1:0]  next_rdata;

   level_if #(.W(LINES_P)) lv ();
   assign lv.raw   = pin_in;
   assign lv.limit = debounce;
   assign clean_level = lv.clean;

   line_debouncer #(.W(LINES_P), .CW(DEB_W)) u_deb (
      .mclk_in  (mclk_in),
      .reset_in (reset_in),
      .lv       (lv)
   );

   edge_events #(.W(LINES_P)) u_edge (
      .mclk_in   (mclk_in),
      .reset_in  (reset_in),
      .level_in  (clean_level),
      .enable_in (edge_enable),
      .rising_in (edge_rising),
      .event_out (events)
   );

   // ==========================================================
   // Line drive control
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         line_drive_enable_bit <= RST_LINES;
         line_drive_value_bit  <= RST_LINES;
      end else if (wr_in) begin
         if (addr_in == OFS_DRIVE_ENABLE)
            line_drive_enable_bit <= wdata_in[LINES_P-1:0];
         if (addr_in == OFS_DRIVE_VALUE)
            line_drive_value_bit <= wdata_in[LINES_P-1:0];
      end
   end

   // Pins registered so outputs come from flops; one cycle of drive lag
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         pin_oe_n_out <= ~RST_LINES;
         pin_out      <= RST_LINES;
      end else begin
         pin_oe_n_out <= ~line_drive_enable_bit;
         pin_out      <= line_drive_value_bit & line_drive_enable_bit;
      end
   end

   // ==========================================================
   // Shared configuration
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         pull_sel <= RST_PULL;
         debounce <= RST_DEBOUNCE;
      end else if (wr_in) begin
         if (addr_in == OFS_PULL_SELECT)
            pull_sel <= pull_sel_t'(wdata_in[1:0]);
         if (addr_in == OFS_DEBOUNCE)
            debounce <= wdata_in[DEB_W-1:0];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in)
         pull_sel_out <= RST_PULL;
      else
         pull_sel_out <= pull_sel;
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         edge_enable <= RST_LINES;
         edge_rising <= RST_LINES;
         irq_mask    <= RST_LINES;
      end else if (wr_in) begin
         if (addr_in == OFS_EDGE_ENABLE)
            edge_enable <= wdata_in[LINES_P-1:0];
         if (addr_in == OFS_EDGE_RISING)
            edge_rising <= wdata_in[LINES_P-1:0];
         if (addr_in == OFS_IRQ_MASK)
            irq_mask <= wdata_in[LINES_P-1:0];
      end
   end

   // ==========================================================
   // Interrupt status: a new event beats a same-cycle clear
   always_ff @(posedge mclk_in) begin
      if (reset_in)
         irq_status <= RST_LINES;
      else if (wr_in && addr_in == OFS_IRQ_STATUS)
         irq_status <= (irq_status & ~wdata_in[LINES_P-1:0]) | events;
      else
         irq_status <= irq_status | events;
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in)
         irq_out <= 1'b0;
      else
         irq_out <= |(irq_status & irq_mask);
   end

   // ==========================================================
   // Register read; unmapped offsets read zero
   always_comb begin
      next_rdata = '0;
      case (addr_in)
         OFS_DRIVE_ENABLE: next_rdata[LINES_P-1:0] = line_drive_enable_bit;
         OFS_DRIVE_VALUE:  next_rdata[LINES_P-1:0] = line_drive_value_bit;
         OFS_PIN_LEVEL:    next_rdata[LINES_P-1:0] = pin_in;
         OFS_PULL_SELECT:  next_rdata[1:0]         = pull_sel;
         OFS_DEBOUNCE:     next_rdata[DEB_W-1:0]   = debounce;
         OFS_EDGE_ENABLE:  next_rdata[LINES_P-1:0] = edge_enable;
         OFS_EDGE_RISING:  next_rdata[LINES_P-1:0] = edge_rising;
         OFS_IRQ_STATUS:   next_rdata[LINES_P-1:0] = irq_status;
         OFS_IRQ_MASK:     next_rdata[LINES_P-1:0] = irq_mask;
         default:          next_rdata = '0;
      endcase
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge mclk_in) begin
      if (reset_in)
         rdata_out <= '0;
      else if (rd_in)
         rdata_out <= next_rdata;
      else
         rdata_out <= '0;
   end

   // ==========================================================
   // Checks
   property p_reset_inputs;
      @(posedge mclk_in) $past(reset_in) |-> (pin_oe_n_out == '1);
   endproperty
   a_reset_inputs: assert property (p_reset_inputs) else $error("lines not inputs after reset");

   property p_pull_reset;
      @(posedge mclk_in) $past(reset_in) |-> (pull_sel == PULL_OPEN);
   endproperty
   a_pull_reset: assert property (p_pull_reset) else $error("pull not open after reset");

   property p_drive_follow;
      @(posedge mclk_in) disable iff (reset_in)
         ##1 (pin_oe_n_out == ~$past(line_drive_enable_bit));
   endproperty
   a_drive_follow: assert property (p_drive_follow) else $error("enable not on pin");

   property p_value_gated;
      @(posedge mclk_in) disable iff (reset_in) ((pin_out & pin_oe_n_out) == '0);
   endproperty
   a_value_gated: assert property (p_value_gated) else $error("value driven while disabled");

   sequence s_pull_write;
      wr_in && addr_in == OFS_PULL_SELECT;
   endsequence
   property p_pull_write;
      @(posedge mclk_in) disable iff (reset_in)
         s_pull_write ##1 1'b1 |-> ##1 (pull_sel_out == $past(wdata_in[1:0], 2));
   endproperty
   a_pull_write: assert property (p_pull_write) else $error("pull select not applied");

   property p_bypass;
      @(posedge mclk_in) disable iff (reset_in) (debounce == '0) |-> (clean_level == pin_in);
   endproperty
   a_bypass: assert property (p_bypass) else $error("zero debounce not transparent");

   property p_event_sticky;
      @(posedge mclk_in) disable iff (reset_in) |events |=> ((irq_status & $past(events)) == $past(events));
   endproperty
   a_event_sticky: assert property (p_event_sticky) else $error("event lost");

   property p_event_enable;
      @(posedge mclk_in) disable iff (reset_in) ((events & ~$past(edge_enable)) == '0);
   endproperty
   a_event_enable: assert property (p_event_enable) else $error("disabled line raised event");

   property p_read_level;
      @(posedge mclk_in) disable iff (reset_in)
         (rd_in && addr_in == OFS_PIN_LEVEL) |=> (rdata_out[LINES_P-1:0] == $past(pin_in));
   endproperty
   a_read_level: assert property (p_read_level) else $error("pin level misread");

   // ==========================================================
   // Checks on the drive, configuration, event and read paths

   property p_reset_drive_zero;
      @(posedge mclk_in) $past(reset_in) |-> (pin_out == '0);
   endproperty
   a_reset_drive_zero: assert property (p_reset_drive_zero) else $error("line value not cleared by reset");

   property p_enable_write;
      @(posedge mclk_in) disable iff (reset_in)
         (wr_in && addr_in == OFS_DRIVE_ENABLE) |=> (line_drive_enable_bit == $past(wdata_in[LINES_P-1:0]));
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("drive enable not written");

   property p_value_write;
      @(posedge mclk_in) disable iff (reset_in)
         (wr_in && addr_in == OFS_DRIVE_VALUE) |=> (line_drive_value_bit == $past(wdata_in[LINES_P-1:0]));
   endproperty
   a_value_write: assert property (p_value_write) else $error("drive value not written");

   property p_drive_value;
      @(posedge mclk_in) disable iff (reset_in)
         1'b1 |=> (pin_out == ($past(line_drive_value_bit) & $past(line_drive_enable_bit)));
   endproperty
   a_drive_value: assert property (p_drive_value) else $error("driven value wrong");

   property p_pull_hold;
      @(posedge mclk_in) disable iff (reset_in)
         !(wr_in && addr_in == OFS_PULL_SELECT) |=> $stable(pull_sel);
   endproperty
   a_pull_hold: assert property (p_pull_hold) else $error("pull select moved without write");

   property p_debounce_write;
      @(posedge mclk_in) disable iff (reset_in)
         (wr_in && addr_in == OFS_DEBOUNCE) |=> (debounce == $past(wdata_in[DEB_W-1:0]));
   endproperty
   a_debounce_write: assert property (p_debounce_write) else $error("debounce setting not written");

   // A filtered level may only move to what the pin showed last cycle
   property p_deb_take;
      @(posedge mclk_in) disable iff (reset_in)
         ((debounce != '0) && ($past(debounce) != '0))
            |-> (((clean_level ^ $past(clean_level)) & (clean_level ^ $past(pin_in))) == '0);
   endproperty
   a_deb_take: assert property (p_deb_take) else $error("filtered level not from pin");

   // Edge history is cleared by reset, so skip the edge right after it
   property p_rise_event;
      @(posedge mclk_in) disable iff (reset_in)
         !$past(reset_in) |-> ((events & $past(edge_rising))
            == ($past(edge_enable) & $past(edge_rising) & $past(clean_level) & ~$past(clean_level, 2)));
   endproperty
   a_rise_event: assert property (p_rise_event) else $error("rising edge event wrong");

   property p_fall_event;
      @(posedge mclk_in) disable iff (reset_in)
         !$past(reset_in) |-> ((events & ~$past(edge_rising))
            == ($past(edge_enable) & ~$past(edge_rising) & ~$past(clean_level) & $past(clean_level, 2)));
   endproperty
   a_fall_event: assert property (p_fall_event) else $error("falling edge event wrong");

   property p_clear_w1c;
      @(posedge mclk_in) disable iff (reset_in)
         (wr_in && addr_in == OFS_IRQ_STATUS)
            |=> ((irq_status & $past(wdata_in[LINES_P-1:0]) & ~$past(events)) == '0);
   endproperty
   a_clear_w1c: assert property (p_clear_w1c) else $error("status bit not cleared");

   property p_status_hold;
      @(posedge mclk_in) disable iff (reset_in)
         (!(wr_in && addr_in == OFS_IRQ_STATUS) && (events == '0)) |=> $stable(irq_status);
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status moved without cause");

   sequence s_unmasked_event;
      (|(events & irq_mask)) && !(wr_in && addr_in == OFS_IRQ_MASK);
   endsequence
   property p_irq_follow;
      @(posedge mclk_in) disable iff (reset_in) s_unmasked_event |=> ##1 irq_out;
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("unmasked event raised no interrupt");

   property p_read_status;
      @(posedge mclk_in) disable iff (reset_in)
         (rd_in && addr_in == OFS_IRQ_STATUS) |=> (rdata_out[LINES_P-1:0] == $past(irq_status));
   endproperty
   a_read_status: assert property (p_read_status) else $error("status misread");

   property p_read_upper;
      @(posedge mclk_in) disable iff (reset_in) 1'b1 |=> (rdata_out[DATA_W-1:LINES_P] == '0);
   endproperty
   a_read_upper: assert property (p_read_upper) else $error("bits above the lines not zero");
endmodule // digital_io_port

// >>> testbench/ext_equipment.sv
module ext_equipment #(
   parameter int W = 20
) (
   input  wire logic         mclk_in,
   input  wire logic [W-1:0] drive_in,
   input  wire logic [W-1:0] drive_oe_n_in,
   input  wire logic [1:0]   pull_in,
   input  wire logic [W-1:0] ext_en_in,
   input  wire logic [W-1:0] ext_val_in,
   output logic      [W-1:0] level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [W-1:0] last = '0;
   logic [W-1:0] idle;
   // ==========================================================
   // Shared pull rail
   always_ff @(posedge mclk_in) begin
      last <= level_out;
   end
   // Open rail floats: toggle so no settled value is trusted
   always_comb begin
      case (pull_in)
         2'h1, 2'h2: idle = '1;
         2'h3:       idle = '0;
         default:    idle = ~last;
      endcase
   end
   // ==========================================================
   // Wire level: board driver, then far equipment, then rail
   assign level_out = (~drive_oe_n_in & drive_in)
                    | (drive_oe_n_in & ext_en_in & ext_val_in)
                    | (drive_oe_n_in & ~ext_en_in & idle);
endmodule // ext_equipment

// >>> testbench/digital_io_port_bench.sv
module digital_io_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import dio_pkg::*;
   logic                    mclk_in;
   logic                    reset_in;
   logic [ADDR_W-1:0]       addr;
   logic [DATA_W-1:0]       wdata;
   logic                    wr;
   logic                    rd;
   logic [DATA_W-1:0]       rdata;
   logic [LINES-1:0]        pin_level;
   logic [LINES-1:0]        pin_drv;
   logic [LINES-1:0]        pin_oe_n;
   logic [1:0]              pull_sel;
   logic                    irq;
   logic [LINES-1:0]        ext_val;
   int                      errors;
   int                      total_checks;
   logic [7:0]              regs [9];
   digital_io_port i_digital_io_port (.mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .pin_in(pin_level), .pin_out(pin_drv),
      .pin_oe_n_out(pin_oe_n), .pull_sel_out(pull_sel), .irq_out(irq));
   // Lines 3 and 4 are driven from the far side only
   ext_equipment i_ext_equipment (.mclk_in(mclk_in), .drive_in(pin_drv), .drive_oe_n_in(pin_oe_n),
      .pull_in(pull_sel), .ext_en_in(20'h0_0018), .ext_val_in(ext_val), .level_out(pin_level));
   // ==========================================================
   // Tasks
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk_in);
      wr    <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      @(posedge mclk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk_in);
      rd   <= 1'b0;
      #1;
      check(rdata & m, exp & m, "register read");
   endtask
   // ==========================================================
   // Clock and watchdog
   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   initial begin
      repeat (5000) @(posedge mclk_in);
      errors++;
      $display("ERROR at %0t: watchdog expired", $time);
      wrap_up();
   end
   // ==========================================================
   // Tests
   initial begin
      reset_in = 1'b1;
      addr     = 8'h00;
      wdata    = 32'h0000_0000;
      wr       = 1'b0;
      rd       = 1'b0;
      ext_val  = 20'h0_0000;
      regs     = '{OFS_DRIVE_ENABLE, OFS_DRIVE_VALUE, OFS_PULL_SELECT, OFS_DEBOUNCE, OFS_EDGE_ENABLE,
                   OFS_EDGE_RISING, OFS_IRQ_STATUS, OFS_IRQ_MASK, 8'hFC};
      repeat (10) @(posedge mclk_in);
      reset_in <= 1'b0;
      settle(1);
      check({12'h000, pin_oe_n}, 32'h000F_FFFF, "enables after reset");
      check({30'h0000_0000, pull_sel}, 32'h0000_0000, "pull after reset");
      foreach (regs[i]) reg_rd(regs[i], 32'h0000_0000, 32'hFFFF_FFFF);
      for (int p = 0; p < 4; p++) begin
         reg_wr(OFS_PULL_SELECT, 32'(p));
         settle(2);
         check({30'h0000_0000, pull_sel}, 32'(p), "pull select");
         if (p != 0) reg_rd(OFS_PIN_LEVEL, (p == 3) ? 32'h0000_0000 : 32'h000F_FFE7, 32'h000F_FFE7);
      end
      // Drive values on disabled lines must not leak out
      reg_wr(OFS_DRIVE_ENABLE, 32'h000F_0F00);
      reg_wr(OFS_DRIVE_VALUE, 32'h0005_5FF5);
      settle(2);
      check({12'h000, pin_drv}, 32'h0005_0F00, "drive value");
      check({12'h000, pin_oe_n}, 32'h0000_F0FF, "drive enable");
      reg_rd(OFS_DRIVE_ENABLE, 32'h000F_0F00, 32'hFFFF_FFFF);
      reg_rd(OFS_PIN_LEVEL, 32'h0005_0F00, 32'hFFFF_FFFF);
      // Open-drain style: value held 0, enable inverted
      reg_wr(OFS_DRIVE_ENABLE, 32'h0000_0000);
      reg_wr(OFS_DRIVE_VALUE, 32'h0000_0000);
      reg_wr(OFS_PULL_SELECT, 32'h0000_0002);
      for (int v = 0; v < 2; v++) begin
         reg_wr(OFS_DRIVE_ENABLE, (v == 0) ? 32'h0000_0001 : 32'h0000_0000);
         settle(2);
         reg_rd(OFS_PIN_LEVEL, 32'(v), 32'h0000_0001);
      end
      // Edge events: line 3 rising, line 4 falling
      @(posedge mclk_in);
      ext_val <= 20'h0_0010;
      settle(4);
      reg_wr(OFS_EDGE_ENABLE, 32'h0000_0018);
      reg_wr(OFS_EDGE_RISING, 32'h0000_0008);
      reg_wr(OFS_IRQ_STATUS, 32'h000F_FFFF);
      ext_val <= 20'h0_0008;
      settle(8);
      reg_rd(OFS_IRQ_STATUS, 32'h0000_0018, 32'hFFFF_FFFF);
      check({31'h0000_0000, irq}, 32'h0000_0000, "masked interrupt");
      reg_wr(OFS_IRQ_MASK, 32'h0000_0008);
      settle(3);
      check({31'h0000_0000, irq}, 32'h0000_0001, "unmasked interrupt");
      reg_wr(OFS_IRQ_STATUS, 32'h0000_0008);
      settle(3);
      check({31'h0000_0000, irq}, 32'h0000_0000, "cleared interrupt");
      @(posedge mclk_in);
      ext_val <= 20'h0_0000;
      settle(8);
      reg_rd(OFS_IRQ_STATUS, 32'h0000_0010, 32'hFFFF_FFFF);
      // Debounce of five cycles: short glitch dropped, long level kept
      reg_wr(OFS_DEBOUNCE, 32'h0000_0005);
      reg_wr(OFS_IRQ_STATUS, 32'h000F_FFFF);
      reg_rd(OFS_DEBOUNCE, 32'h0000_0005, 32'hFFFF_FFFF);
      @(posedge mclk_in);
      ext_val <= 20'h0_0008;
      repeat (4) @(posedge mclk_in);
      ext_val <= 20'h0_0000;
      settle(12);
      reg_rd(OFS_IRQ_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
      @(posedge mclk_in);
      ext_val <= 20'h0_0008;
      settle(12);
      reg_rd(OFS_IRQ_STATUS, 32'h0000_0008, 32'hFFFF_FFFF);
      check({31'h0000_0000, irq}, 32'h0000_0001, "debounced interrupt");
      wrap_up();
   end
endmodule // digital_io_port_bench
